//--- include/hcc_pkg.sv
/*
  Package for the hub charging configuration byte: field positions, reset values,
  and the per-port charging mode codes.
  Assumes the hub core supplies one clock and one asynchronous active-low reset.
*/
package hcc_pkg;
  // ==========================================================================
  // Register layout.
  // ==========================================================================
  localparam logic [3:0] HCC_REG_OFFSET    = 4'hA;     // Offset of the configuration byte.
  localparam int         HCC_REG_W         = 8;        // Register width in bits.
  localparam int         HCC_BIT_UNLOCK    = 6;        // Custom charging unlock.
  localparam int         HCC_BIT_POLARITY  = 5;        // Power-switch enable polarity.
  localparam int         HCC_BIT_HICUR     = 4;        // High-current divider enable.
  localparam int         HCC_RSV_HI        = 3;        // Upper bit of the spare RW pair.
  localparam int         HCC_RSV_LO        = 2;        // Lower bit of the spare RW pair.
  localparam int         HCC_BIT_AUTO_DIS  = 1;        // Automatic mode disable.
  localparam logic [1:0] HCC_RSV_RESET     = 2'h0;     // Reset value of the spare pair.
  localparam logic       HCC_UNLOCK_RESET  = 1'b0;     // Unlock resets cleared.
  localparam logic       HCC_POL_RESET     = 1'b0;     // Polarity until the strap is caught.
  localparam logic       HCC_HICUR_RESET   = 1'b1;     // High-current field reset value.
  localparam logic       HCC_AUTO_RESET    = 1'b0;     // Automatic mode enabled at reset.
  localparam logic       HCC_RSV_READ      = 1'b0;     // Read-only reserved bits read zero.
  localparam int         HCC_PORTS         = 4;        // Downstream charging ports.

  // ==========================================================================
  // Per-port charging mode codes.
  // ==========================================================================
  typedef enum logic [4:0] {
    HCC_MODE_OFF  = 5'h01, // Charging not enabled on the port.
    HCC_MODE_CDP  = 5'h02, // Charging downstream port, upstream connected.
    HCC_MODE_DCP  = 5'h04, // Dedicated charging only.
    HCC_MODE_ACP2 = 5'h08, // Automatic, standard divider level.
    HCC_MODE_ACP3 = 5'h10  // Automatic, high-current divider level.
  } hcc_mode_e;
endpackage

//--- core/hcc_port_mode.sv
/*
  Per-port charging mode selector: one registered mode code per downstream port.
  Assumes all inputs come from logic on ref_clk.
*/
module hcc_port_mode
  import hcc_pkg::*;
(
  input  wire logic        ref_clk,            // Hub core clock.
  input  wire logic        arst_n,             // Asynchronous reset, active low.
  input  wire logic        charge_enable,      // Port has charging enabled.
  input  wire logic        upstream_connected, // Upstream port is connected.
  input  wire logic        auto_disable,       // Automatic mode disabled.
  input  wire logic        hicur_enable,       // High-current divider enabled.
  output hcc_pkg::hcc_mode_e mode_ff           // Registered charging mode.
);
  import hcc_pkg::*;

  hcc_mode_e nxt_mode; // Next mode code.

  // ==========================================================================
  // Mode selection.
  // ==========================================================================
  // Upstream connection overrides the automatic setting entirely.
  always_comb begin
    if (!charge_enable) begin
      nxt_mode = HCC_MODE_OFF;
    end else if (upstream_connected) begin
      nxt_mode = HCC_MODE_CDP;
    end else if (auto_disable) begin
      nxt_mode = HCC_MODE_DCP;
    end else if (hicur_enable) begin
      nxt_mode = HCC_MODE_ACP3;
    end else begin
      nxt_mode = HCC_MODE_ACP2;
    end
  end

  // Register the mode so the charging logic sees a clean code.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= HCC_MODE_OFF;
    end else begin
      mode_ff <= nxt_mode;
    end
  end
endmodule

//--- core/hcc_config.sv
/*
  Charging configuration byte of the hub: holds unlock, polarity, high-current and
  automatic-disable fields, drives the power-switch enables and per-port modes.
  Assumes OTP, EEPROM and SMBus strobes come from logic on ref_clk; only the
  polarity strap is an asynchronous pin.
*/
// Operation
// - High-current field picks ACP3, else ACP2.
// - High-current field writable only by a byte that also sets the unlock bit.
// - Locked reads return the OTP high-current value.
// - Automatic mode only on enabled, unconnected ports.
// - Auto-disable set means dedicated charging only on enabled, unconnected ports.
// - Connected upstream gives CDP on enabled ports.
// - Unlock selects OTP or EEPROM/SMBus source.
module hcc_config
  import hcc_pkg::*;
#(
  parameter int PORTS = HCC_PORTS // Number of downstream ports.
) (
  input  wire logic                         ref_clk,            // Hub core clock, 20 MHz.
  input  wire logic                         arst_n,             // Asynchronous reset, active low.
  input  wire logic                         power_polarity_strap, // Polarity strap pin.
  input  wire logic                         otp_load_valid,     // OTP high-current value strobe.
  input  wire logic                         otp_hicur_value,    // OTP high-current value.
  input  wire logic                         smbus_mode,         // One for SMBus, zero for EEPROM mode.
  input  wire logic                         eeprom_load_valid,  // EEPROM byte load strobe.
  input  wire logic [HCC_REG_W-1:0]         eeprom_load_data,   // EEPROM byte.
  input  wire logic                         smbus_wr_valid,     // SMBus host write strobe.
  input  wire logic [HCC_REG_W-1:0]         smbus_wr_data,      // SMBus host write byte.
  input  wire logic                         upstream_connected, // Upstream port connected.
  input  wire logic [PORTS-1:0]             port_charge_enable, // Charging enabled per port.
  input  wire logic [PORTS-1:0]             port_power_on,      // Power requested per port.
  output logic      [HCC_REG_W-1:0]         reg_rd_data_ff,     // Register read view.
  output logic                              high_current_divider_enable_ff, // Effective divider mode.
  output logic      [PORTS-1:0]             power_switch_enable_ff, // Power-switch pins.
  output hcc_pkg::hcc_mode_e [PORTS-1:0]    port_mode_ff        // Charging mode per port.
);
  import hcc_pkg::*;

  // ==========================================================================
  // Strap synchroniser and capture.
  // ==========================================================================
  logic strap_meta_ff;  // First synchroniser stage, read only by the second.
  logic strap_sync_ff;  // Second synchroniser stage.
  logic strap_taken_ff; // Strap already copied into the polarity field.
  logic strap_arm_ff;   // Set one edge after release: the first stage holds the pin.
  logic strap_ready_ff; // Set two edges after release: the second stage holds the pin.
  logic nxt_strap_taken;

  // Two flops before the strap is used; the pin is not on ref_clk. The ready
  // pair tracks the stages, so the field never copies the stages' reset level.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_meta_ff  <= 1'b0;
      strap_sync_ff  <= 1'b0;
      strap_arm_ff   <= 1'b0;
      strap_ready_ff <= 1'b0;
    end else begin
      strap_meta_ff  <= power_polarity_strap;
      strap_sync_ff  <= strap_meta_ff;
      strap_arm_ff   <= 1'b1;
      strap_ready_ff <= strap_arm_ff;
    end
  end

  // ==========================================================================
  // Register fields.
  // ==========================================================================
  logic       unlock_ff;     // Custom charging unlock.
  logic       polarity_ff;   // Power-switch polarity.
  logic       hicur_ff;      // Writable high-current copy.
  logic       otp_hicur_ff;  // OTP high-current shadow.
  logic [1:0] spare_ff;      // Spare read/write pair.
  logic       auto_dis_ff;   // Automatic mode disable.
  logic       nxt_unlock;
  logic       nxt_polarity;
  logic       nxt_hicur;
  logic       nxt_otp_hicur;
  logic [1:0] nxt_spare;
  logic       nxt_auto_dis;
  logic       wr_valid;      // Host-side write from the active source.
  logic [HCC_REG_W-1:0] wr_data;
  logic       hicur_eff;     // High-current value the port logic uses.

  // The loader and the host never act together: the mode pin picks one.
  always_comb begin
    wr_valid = smbus_mode ? smbus_wr_valid : eeprom_load_valid;
    wr_data  = smbus_mode ? smbus_wr_data : eeprom_load_data;
  end

  // Next field values. The strap is taken once, at the third edge after release
  // when the second stage holds it, and a write in that same cycle wins since
  // it is the newer intent.
  always_comb begin
    nxt_unlock      = unlock_ff;
    nxt_polarity    = polarity_ff;
    nxt_hicur       = hicur_ff;
    nxt_spare       = spare_ff;
    nxt_auto_dis    = auto_dis_ff;
    nxt_strap_taken = strap_taken_ff | strap_ready_ff;
    nxt_otp_hicur   = otp_load_valid ? otp_hicur_value : otp_hicur_ff;
    if (strap_ready_ff && !strap_taken_ff) begin
      nxt_polarity = strap_sync_ff;
    end
    if (wr_valid) begin
      nxt_unlock   = wr_data[HCC_BIT_UNLOCK];
      nxt_polarity = wr_data[HCC_BIT_POLARITY];
      nxt_spare    = wr_data[HCC_RSV_HI:HCC_RSV_LO];
      nxt_auto_dis = wr_data[HCC_BIT_AUTO_DIS];
      // Unlock written in the same byte already opens the field.
      if (wr_data[HCC_BIT_UNLOCK]) begin
        nxt_hicur = wr_data[HCC_BIT_HICUR];
      end
    end
  end

  // Field storage.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_ff      <= HCC_UNLOCK_RESET;
      polarity_ff    <= HCC_POL_RESET;
      hicur_ff       <= HCC_HICUR_RESET;
      otp_hicur_ff   <= HCC_HICUR_RESET;
      spare_ff       <= HCC_RSV_RESET;
      auto_dis_ff    <= HCC_AUTO_RESET;
      strap_taken_ff <= 1'b0;
    end else begin
      unlock_ff      <= nxt_unlock;
      polarity_ff    <= nxt_polarity;
      hicur_ff       <= nxt_hicur;
      otp_hicur_ff   <= nxt_otp_hicur;
      spare_ff       <= nxt_spare;
      auto_dis_ff    <= nxt_auto_dis;
      strap_taken_ff <= nxt_strap_taken;
    end
  end

  // ==========================================================================
  // Read view and outputs.
  // ==========================================================================
  logic [HCC_REG_W-1:0] nxt_rd_data;
  logic                 nxt_divider;
  logic [PORTS-1:0]     nxt_switch;

  // Locked, the high-current bit is whatever OTP holds.
  always_comb begin
    hicur_eff   = unlock_ff ? hicur_ff : otp_hicur_ff;
    nxt_rd_data = '0;
    nxt_rd_data[HCC_REG_W-1]                 = HCC_RSV_READ;
    nxt_rd_data[HCC_BIT_UNLOCK]              = unlock_ff;
    nxt_rd_data[HCC_BIT_POLARITY]            = polarity_ff;
    nxt_rd_data[HCC_BIT_HICUR]               = hicur_eff;
    nxt_rd_data[HCC_RSV_HI:HCC_RSV_LO]       = spare_ff;
    nxt_rd_data[HCC_BIT_AUTO_DIS]            = auto_dis_ff;
    nxt_rd_data[0]                           = HCC_RSV_READ;
    nxt_divider = hicur_eff;
    // Active-high switches follow the request; active-low ones invert it.
    nxt_switch  = polarity_ff ? port_power_on : ~port_power_on;
  end

  // Outputs come from flops; the switch pins reset to the off level of the
  // reset polarity, which is active low.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rd_data_ff                 <= '0;
      high_current_divider_enable_ff <= HCC_HICUR_RESET;
      power_switch_enable_ff         <= '1;
    end else begin
      reg_rd_data_ff                 <= nxt_rd_data;
      high_current_divider_enable_ff <= nxt_divider;
      power_switch_enable_ff         <= nxt_switch;
    end
  end

  // ==========================================================================
  // Per-port mode selectors.
  // ==========================================================================
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    hcc_port_mode u_mode (
      .ref_clk            (ref_clk),
      .arst_n             (arst_n),
      .charge_enable      (port_charge_enable[p]),
      .upstream_connected (upstream_connected),
      .auto_disable       (auto_dis_ff),
      .hicur_enable       (hicur_eff),
      .mode_ff            (port_mode_ff[p])
    );
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_locked_write;
    wr_valid && !wr_data[HCC_BIT_UNLOCK] && !unlock_ff;
  endsequence

  sequence s_unlocked_write;
    wr_valid && wr_data[HCC_BIT_UNLOCK];
  endsequence

  AST_ACP2_LEVEL: assert property (
    port_charge_enable[0] && !upstream_connected && !auto_dis_ff && !hicur_eff
    |=> port_mode_ff[0] == HCC_MODE_ACP2)
    else $error("Port 0 not at ACP2 level.");

  AST_LOCKED_HOLD: assert property (
    s_locked_write |=> $stable(hicur_ff))
    else $error("High-current copy changed while locked.");

  AST_UNLOCK_WRITE: assert property (
    s_unlocked_write ##1 !wr_valid [*2] |-> reg_rd_data_ff[HCC_BIT_HICUR] == $past(wr_data[HCC_BIT_HICUR], 2))
    else $error("Unlocked write of high-current bit not seen.");

  AST_LOCKED_READ: assert property (
    arst_n && !unlock_ff |=> reg_rd_data_ff[HCC_BIT_HICUR] == $past(otp_hicur_ff))
    else $error("Locked read not from OTP.");

  AST_OFF_PORT: assert property (
    !port_charge_enable[0] |=> port_mode_ff[0] == HCC_MODE_OFF)
    else $error("Disabled port not off.");

  AST_DCP_ONLY: assert property (
    port_charge_enable[0] && !upstream_connected && auto_dis_ff |=> port_mode_ff[0] == HCC_MODE_DCP)
    else $error("Auto disabled but port not DCP.");

  AST_CDP: assert property (
    port_charge_enable[0] && upstream_connected |=> port_mode_ff[0] == HCC_MODE_CDP)
    else $error("Connected upstream but port not CDP.");

  AST_OTP_SOURCE: assert property (
    otp_load_valid && !unlock_ff && !wr_valid ##1 !wr_valid
    |=> reg_rd_data_ff[HCC_BIT_HICUR] == $past(otp_hicur_value, 2))
    else $error("OTP load not reflected while locked.");

  AST_POLARITY_PIN: assert property (
    !polarity_ff && !$changed(port_power_on[0]) |=> power_switch_enable_ff[0] == !$past(port_power_on[0]))
    else $error("Active-low switch level wrong.");

  AST_HOST_POL: assert property (
    wr_valid && strap_taken_ff |=> polarity_ff == $past(wr_data[HCC_BIT_POLARITY]))
    else $error("Host polarity write lost.");
endmodule

//--- verif/hcc_host_model.sv
/*
  Behavioural model of the far side of the charging configuration byte: the OTP
  loader, the serial EEPROM loader and the SMBus host, driven through tasks.
  Assumes one clock shared with the block; every strobe lasts one clock cycle.
*/
module hcc_host_model (
  input  wire logic       ref_clk,           // Hub core clock.
  output logic            otp_load_valid,    // OTP value strobe.
  output logic            otp_hicur_value,   // OTP high-current value.
  output logic            eeprom_load_valid, // EEPROM byte strobe.
  output logic [7:0]      eeprom_load_data,  // EEPROM byte.
  output logic            smbus_wr_valid,    // Host write strobe.
  output logic [7:0]      smbus_wr_data      // Host write byte.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle state at time zero.
  // ==========================================================================
  // All strobes start low so nothing is taken before reset releases.
  initial begin
    otp_load_valid    = 1'b0;
    otp_hicur_value   = 1'b0;
    eeprom_load_valid = 1'b0;
    eeprom_load_data  = 8'h00;
    smbus_wr_valid    = 1'b0;
    smbus_wr_data     = 8'h00;
  end

  // ==========================================================================
  // Transfers.
  // ==========================================================================
  // One whole byte from the EEPROM loader or the host; once the strobe drops the
  // data lines show the inverse, so a design that samples late sees a wrong byte.
  task automatic send(input logic from_host, input logic [7:0] b);
    @(posedge ref_clk);
    if (from_host) begin
      smbus_wr_valid <= 1'b1;
      smbus_wr_data  <= b;
    end else begin
      eeprom_load_valid <= 1'b1;
      eeprom_load_data  <= b;
    end
    @(posedge ref_clk);
    smbus_wr_valid    <= 1'b0;
    eeprom_load_valid <= 1'b0;
    smbus_wr_data     <= ~b;
    eeprom_load_data  <= ~b;
  endtask

  // One OTP shadow load of the high-current value.
  task automatic otp(input logic v);
    @(posedge ref_clk);
    otp_load_valid  <= 1'b1;
    otp_hicur_value <= v;
    @(posedge ref_clk);
    otp_load_valid  <= 1'b0;
    otp_hicur_value <= ~v;
  endtask
endmodule

//--- verif/hub_charging_config_bits_tb_top.sv
/*
  Self-checking testbench of the charging configuration byte: corner bytes through
  the SMBus host, random bytes through both sources, random port conditions, OTP loads.
  Assumes the host model beside it and the strap held high from time zero.
*/
module hub_charging_config_bits_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hcc_pkg::*;

  // ==========================================================================
  // Signals and reference state.
  // ==========================================================================
  logic             ref_clk, arst_n, strap, smbus_mode, up;     // Clock, reset and levels.
  logic             otp_v, otp_d, ee_v, sm_v;                   // Strobes and OTP value from the model.
  logic [7:0]       ee_d, sm_d, rd;                             // Bytes in and read view.
  logic [3:0]       en, pwr, sw;                                // Per-port levels and pins.
  logic             dv;                                         // Effective divider mode.
  hcc_mode_e [3:0]  mode;                                       // Per-port modes.
  logic             m_unlock, m_pol, m_hw, m_ad, m_otp;         // Expected fields.
  logic [1:0]       m_spare;                                    // Expected spare pair.
  int               n_errors, n_compared;                       // Verdict counters.
  logic [7:0]       b;                                          // Byte under test.
  logic             src;                                        // One for host, zero for EEPROM.
  logic [7:0]       corner[6] = '{8'h52, 8'h14, 8'h40, 8'h7E, 8'h22, 8'h00}; // Hand-picked bytes.

  hcc_config #(.PORTS(4)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .power_polarity_strap(strap),
    .otp_load_valid(otp_v), .otp_hicur_value(otp_d), .smbus_mode(smbus_mode), .eeprom_load_valid(ee_v),
    .eeprom_load_data(ee_d), .smbus_wr_valid(sm_v), .smbus_wr_data(sm_d), .upstream_connected(up),
    .port_charge_enable(en), .port_power_on(pwr), .reg_rd_data_ff(rd),
    .high_current_divider_enable_ff(dv), .power_switch_enable_ff(sw), .port_mode_ff(mode));

  hcc_host_model i_host (.ref_clk(ref_clk), .otp_load_valid(otp_v), .otp_hicur_value(otp_d),
    .eeprom_load_valid(ee_v), .eeprom_load_data(ee_d), .smbus_wr_valid(sm_v), .smbus_wr_data(sm_d));

  // ==========================================================================
  // Expectations.
  // ==========================================================================
  // The written copy only counts while unlocked; otherwise OTP decides.
  function automatic logic eff();
    return m_unlock ? m_hw : m_otp;
  endfunction

  // Read view: bits 7 and 0 always read zero.
  function automatic logic [7:0] exp_reg();
    return {1'b0, m_unlock, m_pol, eff(), m_spare, m_ad, 1'b0};
  endfunction

  // Mode priority: off, then connected, then dedicated, then divider level.
  function automatic hcc_mode_e exp_mode(input logic e);
    if (!e) return HCC_MODE_OFF;
    if (up) return HCC_MODE_CDP;
    if (m_ad) return HCC_MODE_DCP;
    return eff() ? HCC_MODE_ACP3 : HCC_MODE_ACP2;
  endfunction

  // A taken byte updates every field; bit 4 only when bit 6 of the same byte is set.
  task automatic take(input logic [7:0] v);
    m_unlock = v[6];
    m_pol    = v[5];
    if (v[6]) m_hw = v[4];
    m_spare  = v[3:2];
    m_ad     = v[1];
  endtask

  // ==========================================================================
  // Compare tasks.
  // ==========================================================================
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_mode(input hcc_mode_e got, input hcc_mode_e exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: port mode got %h want %h", $time, got, exp);
    end
  endtask

  // Lets three edges land after the last change, then looks between edges.
  task automatic settle_and_check();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check_reg(rd, exp_reg(), "read view");
    check_reg({7'h00, dv}, {7'h00, eff()}, "divider");
    check_reg({4'h0, sw}, {4'h0, m_pol ? pwr : ~pwr}, "switch pins");
    for (int p = 0; p < 4; p++) begin
      check_mode(mode[p], exp_mode(en[p]));
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog.
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The run needs well under a thousand cycles; four thousand means a hang.
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    arst_n = 1'b0; strap = 1'b1; smbus_mode = 1'b1; up = 1'b0; en = 4'h0; pwr = 4'h0;
    n_errors = 0; n_compared = 0;
    m_unlock = 1'b0; m_pol = 1'b1; m_hw = 1'b1; m_ad = 1'b0; m_otp = 1'b1; m_spare = 2'h0;
    void'($urandom(32'h7845_7e56));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    en  <= 4'hF;
    pwr <= 4'h5;
    settle_and_check();
    i_host.otp(1'b0);
    m_otp = 1'b0;
    settle_and_check();
    for (int i = 0; i < 40; i++) begin
      b   = (i < 6) ? corner[i] : 8'($urandom());
      src = (i < 6) ? 1'b1 : 1'($urandom());
      if (i == 20) begin
        i_host.otp(1'b1);
        m_otp = 1'b1;
      end
      @(posedge ref_clk);
      smbus_mode <= (i < 6) ? 1'b1 : 1'($urandom());
      up  <= (i < 6) ? 1'b0 : 1'($urandom());
      en  <= 4'($urandom());
      pwr <= 4'($urandom());
      @(posedge ref_clk);
      i_host.send(src, b);
      if (src === smbus_mode) take(b);
      settle_and_check();
    end
    give_verdict();
  end
endmodule
